// file: adcr_result_regs.sv
// Converter result registers with Wishbone access, buffering and trigger
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module adcr_result_regs
    import adcr_pkg::*;
#(
    parameter int RES_W = ADCR_RES_W
)
(
    // Power-on reset, manual reset and standby are all synchronous levels
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               manual_reset_i,
    input  wire logic               standby_i,
    // Wishbone classic slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [5:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic                    wb_ack_o,
    output logic      [31:0]        wb_dat_o,
    // Converter group zero, channels 0-3
    input  wire logic               grp0_done_i,
    input  wire logic [1:0]         grp0_chan_i,
    input  wire logic [RES_W-1:0]   grp0_data_i,
    // Converter group one, channels 4-7
    input  wire logic               grp1_done_i,
    input  wire logic [1:0]         grp1_chan_i,
    input  wire logic [RES_W-1:0]   grp1_data_i,
    // External trigger and start request
    input  wire logic               ext_conv_trigger_n_i,
    output logic                    conv_start_o,
    output logic      [1:0]         buf_ptr_o
);

    // ==========================================================
    // Declarations
    // Bus decode and capture
    logic                  req_w;
    logic                  pend_q;
    logic                  is_result_w;
    logic                  is_result_q;
    logic                  is_ctrl_q;
    logic                  is_stat_q;
    logic [3:0]            sel_q;
    logic [1:0]            ctrl_q;
    // Trigger edge detect
    logic                  trig_prev_q;
    logic                  trig_fall_w;
    // Deposit and read paths
    logic [ADCR_CH_W-1:0]  wr_a_addr_w;
    logic [ADCR_CH_W-1:0]  wr_b_addr_w;
    logic [RES_W-1:0]      rd_res_w;
    logic [ADCR_REG_W-1:0] res_word_w;
    logic [7:0]            res_byte_w;
    logic [31:0]           rd_mux_w;

    // Take a new request only while no answer is in flight
    assign req_w       = wb_cyc_i && wb_stb_i && !wb_ack_o && !pend_q;
    // Every address up to 0x1C, the base of the last result word; 0x1D to 0x1F are not decoded as results
    assign is_result_w = wb_adr_i <= ADCR_OFS_RESULT_H;

    // ==========================================================
    // Deposit addressing
    // Linear channel map
    always_comb
    begin
        if (ctrl_q[ADCR_CTRL_BUF_EN_BIT])
        begin
            wr_a_addr_w = {1'b0, buf_ptr_o};
        end
        else
        begin
            wr_a_addr_w = {1'b0, grp0_chan_i};
        end
    end

    // Groups write disjoint halves, so the two ports never clash
    // Even in buffer mode group zero stays inside registers a to d
    // Group one owns upper half
    assign wr_b_addr_w = {1'b1, grp1_chan_i};

    // ==========================================================
    // Result storage
    // Deposit per channel
    // Manual reset not wired
    // Read address comes straight from the bus; the registered data
    // lines up with pend_q, so no extra wait state is needed
    adcr_result_mem #(
        .DEPTH (ADCR_NUM_CH),
        .WIDTH (RES_W),
        .AW    (ADCR_CH_W)
    ) u_mem (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clr_i     (standby_i),
        .we_a_i    (grp0_done_i),
        .addr_a_i  (wr_a_addr_w),
        .data_a_i  (grp0_data_i),
        .we_b_i    (grp1_done_i),
        .addr_b_i  (wr_b_addr_w),
        .data_b_i  (grp1_data_i),
        .rd_addr_i (wb_adr_i[4:2]),
        .rd_data_o (rd_res_w)
    );

    // ==========================================================
    // Buffer pointer, steps once per group zero deposit
    // Pointer shows the next slot to be filled and wraps after the fourth
    // Group one deposits never move it
    // Rotate over first four
    always_ff @(posedge clk_i)
    begin
        if (rst_i || manual_reset_i || standby_i)
        begin
            buf_ptr_o <= 2'h0;
        end
        else if (!ctrl_q[ADCR_CTRL_BUF_EN_BIT])
        begin
            buf_ptr_o <= 2'h0; // Restart at register a when re-enabled
        end
        else if (grp0_done_i)
        begin
            buf_ptr_o <= buf_ptr_o + 2'h1;
        end
    end

    // ==========================================================
    // Control register, the only writable word
    // Manual reset clears it too, so triggers and buffering stop after one
    always_ff @(posedge clk_i)
    begin
        if (rst_i || manual_reset_i || standby_i)
        begin
            ctrl_q <= ADCR_CTRL_RESET;
        end
        else if (req_w && wb_we_i && wb_adr_i == ADCR_OFS_CTRL && wb_sel_i[0])
        begin
            ctrl_q <= wb_dat_i[1:0];
        end
    end

    // ==========================================================
    // External trigger: pin is already synchronous, look for a fall
    // Falling edge starts conversion
    assign trig_fall_w = trig_prev_q && !ext_conv_trigger_n_i;

    // Previous pin level, reset to the idle high so no false edge follows reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trig_prev_q <= 1'b1;
        end
        else
        begin
            trig_prev_q <= ext_conv_trigger_n_i;
        end
    end

    // Start pulse gated by enable
    // A fall seen while disabled is dropped, not held for later
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            conv_start_o <= 1'b0;
        end
        else
        begin
            conv_start_o <= trig_fall_w && ctrl_q[ADCR_CTRL_TRIG_EN_BIT];
        end
    end

    // ==========================================================
    // Bus request capture; memory read runs in the same cycle
    // Pending flag blocks a second take until ack rises; ack then blocks it until the answer has gone
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_q <= 1'b0;
        end
        else
        begin
            pend_q <= req_w;
        end
    end

    // Decode and lanes captured every cycle; only used under pend_q
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            is_result_q <= 1'b0;
            is_ctrl_q   <= 1'b0;
            is_stat_q   <= 1'b0;
            sel_q       <= 4'h0;
        end
        else
        begin
            is_result_q <= is_result_w;
            is_ctrl_q   <= wb_adr_i == ADCR_OFS_CTRL;
            is_stat_q   <= wb_adr_i == ADCR_OFS_STATUS;
            sel_q       <= wb_sel_i;
        end
    end

    // ==========================================================
    // Read formatting
    // Word zero-extended to 16 bits; byte view is result bits 9..2
    assign res_word_w = {{(ADCR_REG_W - RES_W){1'b0}}, rd_res_w};
    assign res_byte_w = rd_res_w[RES_W-1:ADCR_BYTE_LSB];

    // Lane select only matters for result words
    // Unmapped addresses fall through to zero
    always_comb
    begin
        rd_mux_w = 32'h0000_0000;
        if (is_result_q)
        begin
            if (sel_q == ADCR_SEL_LANE0)
            begin
                rd_mux_w[7:0] = res_byte_w;
            end
            else if (sel_q == ADCR_SEL_LANE1)
            begin
                rd_mux_w[15:8] = res_byte_w;
            end
            else
            begin
                rd_mux_w[15:0] = res_word_w;
            end
        end
        else if (is_ctrl_q)
        begin
            rd_mux_w[1:0] = ctrl_q;
        end
        // Status bits are live levels, not captured at the take
        else if (is_stat_q)
        begin
            rd_mux_w[ADCR_STAT_PTR_LSB+:2]  = buf_ptr_o;
            rd_mux_w[ADCR_STAT_TRIG_BIT]    = ext_conv_trigger_n_i;
            rd_mux_w[ADCR_STAT_GRP0_BIT]    = grp0_done_i;
            rd_mux_w[ADCR_STAT_GRP1_BIT]    = grp1_done_i;
        end
    end

    // ==========================================================
    // Answer two edges after the request; writes to results ignored
    // Take at E0, pend_q after E0, ack after E1, sampled by the master at E2
    // Results read-only
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= pend_q;
        end
    end

    // Zero outside the ack cycle keeps stale words off the bus
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (pend_q)
        begin
            wb_dat_o <= rd_mux_w;
        end
        else
        begin
            wb_dat_o <= 32'h0000_0000; // Data only valid with ack
        end
    end

endmodule

// file: adcr_pkg.sv
// Shared constants for the converter result register block
package adcr_pkg;

    // ==========================================================
    // Geometry
    localparam int ADCR_NUM_CH      = 8;
    localparam int ADCR_RES_W       = 10;
    localparam int ADCR_REG_W       = 16;
    localparam int ADCR_CH_W        = 3;
    localparam int ADCR_GRP_CH_W    = 2;
    localparam int ADCR_BUF_DEPTH   = 4;

    // ==========================================================
    // Register byte offsets on the bus
    localparam logic [5:0] ADCR_OFS_RESULT_A = 6'h00;
    localparam logic [5:0] ADCR_OFS_RESULT_H = 6'h1C;
    localparam logic [5:0] ADCR_OFS_CTRL     = 6'h20;
    localparam logic [5:0] ADCR_OFS_STATUS   = 6'h24;

    // ==========================================================
    // Field positions
    localparam int ADCR_CTRL_BUF_EN_BIT  = 0;
    localparam int ADCR_CTRL_TRIG_EN_BIT = 1;
    localparam int ADCR_STAT_PTR_LSB     = 0;
    localparam int ADCR_STAT_TRIG_BIT    = 2;
    localparam int ADCR_STAT_GRP0_BIT    = 4;
    localparam int ADCR_STAT_GRP1_BIT    = 5;
    localparam int ADCR_BYTE_LSB         = 2;

    // ==========================================================
    // Reset values and lane masks
    localparam logic [15:0] ADCR_RESULT_RESET = 16'h0000;
    localparam logic [1:0]  ADCR_CTRL_RESET   = 2'h0;
    localparam logic [3:0]  ADCR_SEL_LANE0    = 4'h1;
    localparam logic [3:0]  ADCR_SEL_LANE1    = 4'h2;

endpackage

// file: adcr_result_mem.sv
// Eight-entry result store with two deposit ports and a registered read port
`timescale 1ns/1ps
module adcr_result_mem
    import adcr_pkg::*;
#(
    parameter int DEPTH = ADCR_NUM_CH,
    parameter int WIDTH = ADCR_RES_W,
    parameter int AW    = ADCR_CH_W
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             clr_i,
    input  wire logic             we_a_i,
    input  wire logic [AW-1:0]    addr_a_i,
    input  wire logic [WIDTH-1:0] data_a_i,
    input  wire logic             we_b_i,
    input  wire logic [AW-1:0]    addr_b_i,
    input  wire logic [WIDTH-1:0] data_b_i,
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    // ==========================================================
    // Storage: one flop group per entry, port b wins on a clash
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_entry
            always_ff @(posedge clk_i)
            begin
                if (rst_i || clr_i)
                begin
                    mem_q[g] <= ADCR_RESULT_RESET[WIDTH-1:0];
                end
                else if (we_b_i && addr_b_i == AW'(g))
                begin
                    mem_q[g] <= data_b_i;
                end
                else if (we_a_i && addr_a_i == AW'(g))
                begin
                    mem_q[g] <= data_a_i;
                end
            end
        end
    endgenerate

    // Read data leaves through a register
    always_ff @(posedge clk_i)
    begin
        if (rst_i || clr_i)
        begin
            rd_data_o <= ADCR_RESULT_RESET[WIDTH-1:0];
        end
        else
        begin
            rd_data_o <= mem_q[rd_addr_i];
        end
    end

endmodule

// file: adcr_result_regs_sva.sv
// Concurrent checks on the ports of the result register block
`timescale 1ns/1ps
module adcr_result_regs_sva
    import adcr_pkg::*;
#(
    parameter int RES_W = ADCR_RES_W
)
(
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               manual_reset_i,
    input wire logic               standby_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [5:0]         wb_adr_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic               wb_ack_o,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               grp0_done_i,
    input wire logic [1:0]         grp0_chan_i,
    input wire logic [RES_W-1:0]   grp0_data_i,
    input wire logic               grp1_done_i,
    input wire logic [1:0]         grp1_chan_i,
    input wire logic [RES_W-1:0]   grp1_data_i,
    input wire logic               ext_conv_trigger_n_i,
    input wire logic               conv_start_o,
    input wire logic [1:0]         buf_ptr_o
);
    // ==========================================================
    // Bus answer
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_latency: assert property ($rose(wb_stb_i) && wb_cyc_i |-> ##1 !wb_ack_o ##1 wb_ack_o)
        else $error("ack not two edges after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack cycle");
    a_top_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i < ADCR_OFS_CTRL && wb_sel_i != ADCR_SEL_LANE0
        && wb_sel_i != ADCR_SEL_LANE1 |-> wb_dat_o[15:10] == 6'h00)
        else $error("result top bits not zero");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 6'h28 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");

    // ==========================================================
    // Trigger, pointer and reset
    a_start_edge: assert property (conv_start_o |-> !$past(ext_conv_trigger_n_i) && $past(ext_conv_trigger_n_i, 2))
        else $error("start without trigger fall");
    a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
        else $error("start longer than one cycle");
    a_ptr_clear: assert property (standby_i || manual_reset_i |=> buf_ptr_o == 2'h0)
        else $error("pointer not cleared");
    // Reset itself must be watched, so no disable here
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !conv_start_o && buf_ptr_o == 2'h0)
        else $error("outputs active after reset");
endmodule

bind adcr_result_regs adcr_result_regs_sva #(.RES_W(RES_W)) u_sva (.clk_i, .rst_i, .manual_reset_i, .standby_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .grp0_done_i,
    .grp0_chan_i, .grp0_data_i, .grp1_done_i, .grp1_chan_i, .grp1_data_i, .ext_conv_trigger_n_i,
    .conv_start_o, .buf_ptr_o);

// file: adcr_result_regs_bench.sv
// Self-checking bench for the result register block
`timescale 1ns/1ps
module adcr_result_regs_bench;
    import adcr_pkg::*;
    logic        clk_i, rst_i, manual_reset_i, standby_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [5:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        wb_ack_o, grp0_done_i, grp1_done_i, ext_conv_trigger_n_i, conv_start_o;
    logic [1:0]  grp0_chan_i, grp1_chan_i, buf_ptr_o;
    logic [9:0]  grp0_data_i, grp1_data_i;
    // Rows: deposit value, expected word view, expected byte view
    logic [33:0] rows [8] = '{{10'h3FF, 16'h03FF, 8'hFF}, {10'h155, 16'h0155, 8'h55}, {10'h2AA, 16'h02AA, 8'hAA},
        {10'h001, 16'h0001, 8'h00}, {10'h200, 16'h0200, 8'h80}, {10'h0FF, 16'h00FF, 8'h3F},
        {10'h300, 16'h0300, 8'hC0}, {10'h1C3, 16'h01C3, 8'h70}};
    int          err_total = 0, samples_checked = 0, cycles = 0, k;

    adcr_result_regs dut (.clk_i, .rst_i, .manual_reset_i, .standby_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .grp0_done_i, .grp0_chan_i, .grp0_data_i,
        .grp1_done_i, .grp1_chan_i, .grp1_data_i, .ext_conv_trigger_n_i, .conv_start_o, .buf_ptr_o);

    // ==========================================================
    // Clock and hang guard, ceiling well above the few hundred cycles used
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_total++;
            test_done();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic test_done;
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled, then release
    task automatic bus(input logic w, input logic [5:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rdchk(input int ch, input logic [3:0] s, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, 6'(ch * 4), s, 32'h0);
        chk("result", e, rd & m);
    endtask

    // One-cycle done pulse on the group that owns the channel
    task automatic dep(input int ch, input logic [9:0] v);
        @(posedge clk_i);
        grp0_done_i <= (ch < 4);
        grp1_done_i <= (ch >= 4);
        grp0_chan_i <= ch[1:0];
        grp1_chan_i <= ch[1:0];
        grp0_data_i <= v;
        // Group one carries the inverse when idle, so a stray deposit would show
        grp1_data_i <= (ch >= 4) ? v : ~v;
        @(posedge clk_i);
        grp0_done_i <= 1'b0;
        grp1_done_i <= 1'b0;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        {clk_i, manual_reset_i, standby_i, wb_cyc_i, wb_stb_i, wb_we_i, grp0_done_i, grp1_done_i} = '0;
        {wb_adr_i, wb_sel_i, wb_dat_i, grp0_chan_i, grp1_chan_i, grp0_data_i, grp1_data_i} = '0;
        rst_i = 1'b1;
        ext_conv_trigger_n_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int c = 0; c < 8; c++) rdchk(c, 4'hF, 32'hFFFF, 32'h0);
        for (int c = 0; c < 8; c++) dep(c, rows[c][33:24]);
        // Row loop: word, low lane and high lane view of every channel
        for (int c = 0; c < 8; c++)
        begin
            rdchk(c, 4'hF, 32'hFFFF_FFFF, {16'h0, rows[c][23:8]});
            rdchk(c, ADCR_SEL_LANE0, 32'hFFFF_FFFF, {24'h0, rows[c][7:0]});
            rdchk(c, ADCR_SEL_LANE1, 32'hFFFF_FFFF, {16'h0, rows[c][7:0], 8'h0});
        end
        bus(1'b1, ADCR_OFS_RESULT_A, 4'hF, 32'hFFFF);
        rdchk(0, 4'hF, 32'hFFFF, {16'h0, rows[0][23:8]});
        bus(1'b0, 6'h28, 4'hF, 32'h0);
        chk("unmapped", 32'h0, rd);
        // Buffer mode: group zero fills registers 0..3 in turn
        bus(1'b1, ADCR_OFS_CTRL, 4'h1, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            dep(2, rows[7 - i][33:24]);
            @(negedge clk_i);
            chk("ptr", 32'((i + 1) % 4), {30'h0, buf_ptr_o});
        end
        for (int i = 0; i < 4; i++) rdchk(i, 4'hF, 32'hFFFF, {16'h0, rows[7 - i][23:8]});
        rdchk(4, 4'hF, 32'hFFFF, {16'h0, rows[4][23:8]});
        // Control and status read back: pointer wrapped, pin idle high
        bus(1'b0, ADCR_OFS_CTRL, 4'hF, 32'h0);
        chk("ctrl", 32'h0000_0001, rd);
        bus(1'b0, ADCR_OFS_STATUS, 4'hF, 32'h0);
        chk("status", 32'h0000_0004, rd);
        // Manual reset: results kept, control back to zero
        @(posedge clk_i);
        manual_reset_i <= 1'b1;
        @(posedge clk_i);
        manual_reset_i <= 1'b0;
        rdchk(7, 4'hF, 32'hFFFF, {16'h0, rows[7][23:8]});
        rdchk(0, 4'hF, 32'hFFFF, {16'h0, rows[7][23:8]});
        bus(1'b0, ADCR_OFS_CTRL, 4'hF, 32'h0);
        chk("ctrl", 32'h0, rd);
        // Trigger refused while disabled, one pulse when enabled
        for (int e = 0; e < 2; e++)
        begin
            bus(1'b1, ADCR_OFS_CTRL, 4'h1, {30'h0, e[0], 1'b0});
            @(posedge clk_i);
            ext_conv_trigger_n_i <= 1'b0;
            k = 0;
            repeat (4) @(negedge clk_i) k += (conv_start_o === 1'b1);
            chk("start", 32'(e), 32'(k));
            @(posedge clk_i);
            ext_conv_trigger_n_i <= 1'b1;
        end
        // Standby clears every result
        @(posedge clk_i);
        standby_i <= 1'b1;
        @(posedge clk_i);
        standby_i <= 1'b0;
        for (int c = 0; c < 8; c++) rdchk(c, 4'hF, 32'hFFFF, 32'h0);
        // Power-on reset in mid-run clears a fresh result
        dep(5, rows[5][33:24]);
        rdchk(5, 4'hF, 32'hFFFF, {16'h0, rows[5][23:8]});
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(5, 4'hF, 32'hFFFF, 32'h0);
        test_done();
    end
endmodule
